// ===== logic/lcd_host_pkg.sv
/*
  Constants and types shared by the LCD host port and its serial
  byte assembler. Assumes nothing of its surroundings.
*/
package lcd_host_pkg;
  localparam int DATA_W = 8;
  localparam int STATUS_W = 7;
  localparam int COL_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_INIT = 3'h0;
  localparam logic [COL_W-1:0] COL_LAST = 8'h83;
  localparam logic [COL_W-1:0] COL_RESET = 8'h00;
  localparam logic [COL_W-1:0] COL_STEP = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
  // Serial pins share the parallel data pads
  localparam int SERIAL_DATA_BIT = 7;
  localparam int SERIAL_CLOCK_BIT = 6;
  // Layout of the synchronised pin vector
  localparam int SYNC_W = 15;
  localparam int S_PS = 14;
  localparam int S_C86 = 13;
  localparam int S_CS1N = 12;
  localparam int S_CS2 = 11;
  localparam int S_A0 = 10;
  localparam int S_RD = 9;
  localparam int S_WR = 8;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 15'h7fff;

  typedef enum logic [2:0] {
    ACC_NONE = 3'b000,
    ACC_DATA_RD = 3'b001,
    ACC_DATA_WR = 3'b010,
    ACC_STATUS_RD = 3'b011,
    ACC_CMD_WR = 3'b100
  } access_t;
endpackage

// ===== logic/host_byte_if.sv
/*
  Carries one assembled serial byte from the assembler to the port
  logic. Assumes a single clock shared by both ends.
*/
`timescale 1ns/100ps
interface host_byte_if;
  logic [7:0] value;
  logic is_data;
  logic valid;
  modport source (output value, output is_data, output valid);
  modport sink (input value, input is_data, input valid);
endinterface

// ===== logic/serial_byte_assembler.sv
/*
  Shifts the write-only serial link into bytes. Inputs are already
  synchronised to clk_i; enable_i is low whenever the link is unusable.
*/
`timescale 1ns/100ps
module serial_byte_assembler
  import lcd_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic dc_i,
  host_byte_if.source out
);
  logic prev_sclk;
  logic [DATA_W-2:0] shift;
  logic [BIT_CNT_W-1:0] count;
  logic sclk_rise;

  assign sclk_rise = enable_i & sclk_i & ~prev_sclk;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_sclk <= 1'b1;
    end else begin
      prev_sclk <= sclk_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift <= '0;
      count <= BIT_CNT_INIT;
    end else if (!enable_i) begin
      shift <= '0;
      count <= BIT_CNT_INIT;
    end else if (sclk_rise) begin
      shift <= {shift[DATA_W-3:0], sdata_i};
      count <= count + 3'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out.value <= BYTE_RESET;
      out.is_data <= 1'b0;
      out.valid <= 1'b0;
    end else begin
      out.valid <= sclk_rise && count == BIT_CNT_LAST;
      if (sclk_rise && count == BIT_CNT_LAST) begin
        out.value <= {shift, sdata_i};
        out.is_data <= dc_i;
      end
    end
  end
endmodule // serial_byte_assembler

// ===== logic/lcd_host_bus_interface.sv
/*
  Host access port of a dot-matrix LCD controller: 8080/6800 parallel
  bus or write-only serial link, bus holder pipeline, column counter.
  Assumes the display RAM answers ram_rdata_i combinationally for
  ram_addr_o, and busy_i, column_set_i come from core logic on clk_i.
*/
// Behaviour
// - Bus type select picks parallel or serial
// - Serial mode is write only
// - Family select picks 6800 or 8080 strobes
// - Select plus direction decode data, status, command
// - Serial accepted only while chip active
// - Serial data sampled on rising clock, MSB first
// - Eighth rising edge delivers the byte
// - Select sampled per byte: low command, high data
// - Deselect resets shifter and bit counter
// - Inactive select floats bus, ignores strobes
// - Data reads come through holder, one behind
// - Write held in holder, committed to RAM
// - Busy accepts status reads only
// - Busy flag shown on D7 in status
// - Column address steps after data access, holds at last column
`timescale 1ns/100ps
module lcd_host_bus_interface
  import lcd_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_type_select_i,
  input wire logic host_bus_family_select_i,
  input wire logic chip_select_low_n_i,
  input wire logic chip_select_high_i,
  input wire logic data_command_select_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [lcd_host_pkg::DATA_W-1:0] data_i,
  input wire logic busy_i,
  input wire logic [lcd_host_pkg::STATUS_W-1:0] status_i,
  input wire logic column_set_i,
  input wire logic [lcd_host_pkg::COL_W-1:0] column_value_i,
  input wire logic [lcd_host_pkg::DATA_W-1:0] ram_rdata_i,
  output logic [lcd_host_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic cmd_valid_o,
  output logic [lcd_host_pkg::DATA_W-1:0] cmd_byte_o,
  output logic [lcd_host_pkg::COL_W-1:0] ram_addr_o,
  output logic [lcd_host_pkg::DATA_W-1:0] ram_wdata_o,
  output logic ram_we_o
);
  import lcd_host_pkg::*;

  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync;
  logic prev_rd;
  logic prev_wr;
  logic prev_fam;
  logic fam_steady;
  logic [COL_W-1:0] col;
  logic active;
  logic parallel;
  logic six800;
  logic reading;
  logic rd_end;
  logic wr_end;
  logic [DATA_W-1:0] holder;
  access_t access;
  logic wr_evt;
  logic wr_is_data;
  logic [DATA_W-1:0] wr_byte;
  logic data_rd_evt;
  logic col_step;

  host_byte_if serial_byte ();

  // Two-flop synchroniser for every host pin
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_meta <= SYNC_RESET;
      sync <= SYNC_RESET;
    end else begin
      sync_meta <= {bus_type_select_i, host_bus_family_select_i,
                    chip_select_low_n_i, chip_select_high_i,
                    data_command_select_i, read_strobe_n_i,
                    write_strobe_n_i, data_i};
      sync <= sync_meta;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_rd <= 1'b1;
      prev_wr <= 1'b1;
      prev_fam <= SYNC_RESET[S_C86];
    end else begin
      prev_rd <= sync[S_RD];
      prev_wr <= sync[S_WR];
      prev_fam <= sync[S_C86];
    end
  end

  assign active = ~sync[S_CS1N] & sync[S_CS2];
  assign parallel = sync[S_PS];
  assign six800 = sync[S_C86];
  // A family change swaps pin meanings; no access edge in that cycle
  assign fam_steady = six800 == prev_fam;

  // 6800: read pin is enable, write pin is read/write select
  always_comb begin
    if (six800) begin
      reading = sync[S_RD] & sync[S_WR];
      rd_end = prev_rd & ~sync[S_RD] & sync[S_WR];
      wr_end = prev_rd & ~sync[S_RD] & ~sync[S_WR];
    end else begin
      reading = ~sync[S_RD];
      rd_end = ~prev_rd & sync[S_RD];
      wr_end = ~prev_wr & sync[S_WR];
    end
  end

  // Parallel access kind, only while selected in parallel mode
  always_comb begin
    access = ACC_NONE;
    if (active && parallel && fam_steady) begin
      if (rd_end) begin
        access = sync[S_A0] ? ACC_DATA_RD : ACC_STATUS_RD;
      end else if (wr_end) begin
        access = sync[S_A0] ? ACC_DATA_WR : ACC_CMD_WR;
      end
    end
  end

  serial_byte_assembler u_serial (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(active & ~parallel),
    .sclk_i(sync[SERIAL_CLOCK_BIT]),
    .sdata_i(sync[SERIAL_DATA_BIT]),
    .dc_i(sync[S_A0]),
    .out(serial_byte.source)
  );

  // Merge parallel writes and serial bytes; busy drops all but status
  always_comb begin
    wr_evt = 1'b0;
    wr_is_data = 1'b0;
    wr_byte = sync[DATA_W-1:0];
    data_rd_evt = 1'b0;
    case (access)
      ACC_DATA_WR: begin
        wr_evt = ~busy_i;
        wr_is_data = 1'b1;
      end
      ACC_CMD_WR: begin
        wr_evt = ~busy_i;
      end
      ACC_DATA_RD: begin
        data_rd_evt = ~busy_i;
      end
      default: begin
        if (serial_byte.valid && !parallel) begin
          wr_evt = ~busy_i;
          wr_is_data = serial_byte.is_data;
          wr_byte = serial_byte.value;
        end
      end
    endcase
  end

  assign col_step = (data_rd_evt || (wr_evt && wr_is_data)) &&
                    col != COL_LAST;

  // Bus holder: reads load it after the host sees the old value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      holder <= BYTE_RESET;
    end else if (data_rd_evt) begin
      holder <= ram_rdata_i;
    end else if (wr_evt && wr_is_data) begin
      holder <= wr_byte;
    end
  end

  // Display RAM write port, committed the cycle after capture
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ram_we_o <= 1'b0;
      ram_wdata_o <= BYTE_RESET;
    end else begin
      ram_we_o <= wr_evt & wr_is_data;
      if (wr_evt && wr_is_data) begin
        ram_wdata_o <= wr_byte;
      end
    end
  end

  // Column counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      col <= COL_RESET;
    end else if (column_set_i) begin
      col <= column_value_i;
    end else if (col_step) begin
      col <= col + COL_STEP;
    end
  end

  // Address lags the column one cycle, so a commit hits the pre-step
  // column; host accesses are many cycles apart, so reads see it settled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ram_addr_o <= COL_RESET;
    end else begin
      ram_addr_o <= col;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_byte_o <= BYTE_RESET;
    end else begin
      cmd_valid_o <= wr_evt & ~wr_is_data;
      if (wr_evt && !wr_is_data) begin
        cmd_byte_o <= wr_byte;
      end
    end
  end

  // Read drive: parallel and selected only; serial never drives
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_oe_o <= 1'b0;
      data_o <= BYTE_RESET;
    end else begin
      data_oe_o <= active & parallel & reading;
      if (active && parallel && reading) begin
        data_o <= sync[S_A0] ? holder : {busy_i, status_i};
      end
    end
  end
endmodule // lcd_host_bus_interface

// ===== bench/lcd_host_checker.sv
/*
  Timing checks on the LCD host port, bound to its top module.
  Assumes one clock and the active-high reset.
*/
`timescale 1ns/100ps
module lcd_host_checker
  import lcd_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_type_select_i,
  input wire logic host_bus_family_select_i,
  input wire logic chip_select_low_n_i,
  input wire logic chip_select_high_i,
  input wire logic data_command_select_i,
  input wire logic read_strobe_n_i,
  input wire logic busy_i,
  input wire logic [lcd_host_pkg::STATUS_W-1:0] status_i,
  input wire logic column_set_i,
  input wire logic [lcd_host_pkg::DATA_W-1:0] data_o,
  input wire logic data_oe_o,
  input wire logic cmd_valid_o,
  input wire logic [lcd_host_pkg::COL_W-1:0] ram_addr_o,
  input wire logic ram_we_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ser;
    !bus_type_select_i [*6] |-> !data_oe_o;
  endproperty
  a_ser: assert property (p_ser)
    else $error("bus driven in serial mode");
  property p_desel;
    chip_select_low_n_i [*6] |-> !data_oe_o;
  endproperty
  a_desel: assert property (p_desel)
    else $error("bus driven while deselected");
  property p_busy;
    busy_i [*3] |-> !ram_we_o && !cmd_valid_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("access taken while busy");
  property p_step;
    ram_we_o && !column_set_i && ram_addr_o != COL_LAST
      |=> ram_addr_o == $past(ram_addr_o) + COL_STEP;
  endproperty
  a_step: assert property (p_step)
    else $error("column did not step");
  property p_stop;
    ram_we_o && !column_set_i && ram_addr_o == COL_LAST
      |=> ram_addr_o == COL_LAST;
  endproperty
  a_stop: assert property (p_stop)
    else $error("column passed its last value");
  property p_status;
    (!data_command_select_i && $stable(busy_i) && $stable(status_i)) [*8]
      ##0 data_oe_o |-> data_o == {busy_i, status_i};
  endproperty
  a_status: assert property (p_status)
    else $error("status word wrong");
  property p_rd_idle;
    (read_strobe_n_i && !host_bus_family_select_i) [*8] |-> !data_oe_o;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("driven without read strobe");
  property p_e_idle;
    (!read_strobe_n_i && host_bus_family_select_i) [*8] |-> !data_oe_o;
  endproperty
  a_e_idle: assert property (p_e_idle)
    else $error("driven with enable low");
  property p_rd_drive;
    (!read_strobe_n_i && !host_bus_family_select_i && bus_type_select_i
      && !chip_select_low_n_i && chip_select_high_i) [*5] |-> data_oe_o;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("bus not driven during read");
endmodule // lcd_host_checker

// ===== bench/lcd_host_model.sv
/*
  Host processor model: parallel cycles and serial bytes on the pins.
  Assumes clk_i runs free; calls start just after a falling edge.
*/
`timescale 1ns/100ps
module lcd_host_model (
  input wire logic clk_i,
  input wire logic [7:0] q_i,
  output logic fam_o = 1'h0,
  output logic csn_o = 1'h0,
  output logic cs_o = 1'h1,
  output logic dc_o = 1'h0,
  output logic rd_o = 1'h1,
  output logic wr_o = 1'h1,
  output logic [7:0] d_o = 8'h00
);
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic sel(input logic n, h);
    wt(1);
    csn_o = n;
    cs_o = h;
    wt(6);
  endtask
  task automatic par(input logic f, a, r, input logic [7:0] w,
      output logic [7:0] q);
    wt(1);
    fam_o = f;
    dc_o = a;
    rd_o = !f;
    wr_o = f ? r : 1'h1;
    d_o = r ? ~d_o : w;
    wt(4);
    if (f) rd_o = 1'h1;
    else if (r) rd_o = 1'h0;
    else wr_o = 1'h0;
    wt(8);
    q = q_i;
    rd_o = !f;
    wr_o = f ? r : 1'h1;
    wt(4);
    // Data hold has run out: show a changed value
    d_o = ~d_o;
    wt(6);
  endtask
  task automatic ser(input logic a, input logic [7:0] b, input int n);
    // Strobes, family and low data pads stay fixed
    d_o[6] = 1'h0;
    dc_o = a;
    for (int i = 7; i > 7 - n; i--) begin
      d_o[7] = b[i];
      #24 d_o[6] = 1'h1;
      #24 d_o[6] = 1'h0;
    end
    d_o[7] = ~d_o[7];
    wt(10);
  endtask
endmodule // lcd_host_model

// ===== bench/lcd_host_bus_interface_bench.sv
/*
  Self-checking bench for the LCD host port. Assumes the host model
  and a behavioural display RAM kept here.
*/
`timescale 1ns/100ps
module lcd_host_bus_interface_bench;
  import lcd_host_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic bus_type = 1'h1;
  logic busy = 1'h0;
  logic col_set = 1'h0;
  logic [6:0] status = 7'h00;
  logic [7:0] col_val = 8'h00;
  logic [7:0] ram [256];
  logic [7:0] q, w0, w1, c, last_cmd, data_o, ram_addr, d, cmd_byte, wdata;
  logic fam, csn, cs, dc, rd, wr, oe, we, cmdv;
  int error_cnt, comparisons, nwe, ncmd, n, cyc;
  integer seed = 32'h850ec533;
  lcd_host_bus_interface dut (
    .clk_i, .rst_i, .bus_type_select_i(bus_type),
    .host_bus_family_select_i(fam), .chip_select_low_n_i(csn),
    .chip_select_high_i(cs), .data_command_select_i(dc),
    .read_strobe_n_i(rd), .write_strobe_n_i(wr), .data_i(d),
    .busy_i(busy), .status_i(status), .column_set_i(col_set),
    .column_value_i(col_val), .ram_rdata_i(ram[ram_addr]),
    .data_o, .data_oe_o(oe), .cmd_valid_o(cmdv), .cmd_byte_o(cmd_byte),
    .ram_addr_o(ram_addr), .ram_wdata_o(wdata), .ram_we_o(we)
  );
  lcd_host_model host (
    .clk_i, .q_i(data_o), .fam_o(fam), .csn_o(csn), .cs_o(cs),
    .dc_o(dc), .rd_o(rd), .wr_o(wr), .d_o(d)
  );
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (we) ram[ram_addr] <= wdata;
    if (we) nwe <= nwe + 1;
    if (cmdv) ncmd <= ncmd + 1;
    if (cmdv) last_cmd <= cmd_byte;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude;
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] status_word(logic b, logic [6:0] s);
    return {b, s};
  endfunction
  task automatic setcol(input logic [7:0] v);
    @(negedge clk_i);
    col_val = v;
    col_set = 1'h1;
    @(negedge clk_i);
    col_set = 1'h0;
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'h0;
    repeat (4) @(negedge clk_i);
    for (int f = 0; f < 2; f++) begin
      c = f ? 8'h82 : 8'($random(seed)) & 8'h7f;
      w0 = 8'($random(seed));
      w1 = 8'($random(seed));
      setcol(c);
      host.par(1'(f), 1'h1, 1'h0, w0, q);
      host.par(1'(f), 1'h1, 1'h0, w1, q);
      chk("ram_first", w0, ram[c]);
      chk("ram_next", w1, ram[c + 8'h01]);
      setcol(c);
      host.par(1'(f), 1'h1, 1'h1, 8'h00, q);
      host.par(1'(f), 1'h1, 1'h1, 8'h00, q);
      chk("read_first", w0, q);
      host.par(1'(f), 1'h1, 1'h1, 8'h00, q);
      chk("read_next", w1, q);
      status = 7'($random(seed));
      host.par(1'(f), 1'h0, 1'h1, 8'h00, q);
      chk("status", status_word(1'h0, status), q);
      host.par(1'(f), 1'h0, 1'h0, w0, q);
      chk("command", w0, last_cmd);
    end
    busy = 1'h1;
    n = nwe;
    host.par(1'h0, 1'h0, 1'h1, 8'h00, q);
    chk("busy_status", status_word(1'h1, status), q);
    host.par(1'h0, 1'h1, 1'h0, 8'h5a, q);
    host.par(1'h0, 1'h0, 1'h0, 8'h3c, q);
    busy = 1'h0;
    chk("busy_writes", 8'(n), 8'(nwe));
    chk("busy_cmd", w0, last_cmd);
    n = ncmd;
    host.sel(1'h1, 1'h1);
    host.par(1'h0, 1'h0, 1'h0, 8'ha5, q);
    host.sel(1'h0, 1'h0);
    host.par(1'h0, 1'h0, 1'h0, 8'ha5, q);
    host.sel(1'h0, 1'h1);
    chk("deselected", 8'(n), 8'(ncmd));
    bus_type = 1'h0;
    w0 = 8'($random(seed));
    w1 = 8'($random(seed));
    host.ser(1'h0, w0, 8);
    chk("serial_cmd", w0, last_cmd);
    host.ser(1'h0, 8'hff, 5);
    host.sel(1'h1, 1'h0);
    host.sel(1'h0, 1'h1);
    host.ser(1'h0, w1, 8);
    chk("serial_fresh", w1, last_cmd);
    host.sel(1'h0, 1'h0);
    host.ser(1'h0, 8'h3c, 8);
    host.sel(1'h0, 1'h1);
    chk("serial_desel", w1, last_cmd);
    setcol(8'h10);
    host.ser(1'h1, w0, 8);
    chk("serial_data", w0, ram[8'h10]);
    conclude();
  end
endmodule // lcd_host_bus_interface_bench
bind lcd_host_bus_interface lcd_host_checker chk_u (
  .clk_i, .rst_i, .bus_type_select_i, .host_bus_family_select_i,
  .chip_select_low_n_i, .chip_select_high_i, .data_command_select_i,
  .read_strobe_n_i,
  .busy_i, .status_i, .column_set_i, .data_o, .data_oe_o,
  .cmd_valid_o, .ram_addr_o, .ram_we_o
);
